// *** shared/two_wire_if.sv ***
// Two-wire bus carrier: clock line and wired-AND data line.
`timescale 1ns/1ps
`default_nettype none

interface two_wire_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  // Open-drain data line: low whenever an enabled driver pulls low.
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (
    output scl,
    output m_sda_o,
    output m_sda_oe,
    input sda
  );

  modport device (
    input scl,
    output s_sda_o,
    output s_sda_oe,
    input sda
  );
endinterface

`default_nettype wire

// *** shared/two_wire_map.svh ***
// Constants for the two-wire address phase: widths, codes and timing.
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH

// ----------------------------------------------------------------------
// Packet layout
// ----------------------------------------------------------------------
`define TW_ADDR_BITS 7
`define TW_PACKET_BITS 9
`define TW_ACK_BIT_IDX 8
`define TW_DIR_READ 1'b1
`define TW_DIR_WRITE 1'b0

// ----------------------------------------------------------------------
// Reserved addresses
// ----------------------------------------------------------------------
`define TW_GC_ADDR 7'h00
`define TW_RSV_TOP 4'hF
`define TW_RSV_MSB 6
`define TW_RSV_LSB 3

// ----------------------------------------------------------------------
// Own address register fields
// ----------------------------------------------------------------------
`define TW_OWN_ADDR_MSB 7
`define TW_OWN_ADDR_LSB 1
`define TW_GCE_BIT 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TW_SYS_CLK_MHZ 20
`define TW_SCL_HALF_NS 1000
`define TW_SCL_HALF_CYC ((`TW_SCL_HALF_NS * `TW_SYS_CLK_MHZ + 999) / 1000)

`endif

// *** shared/two_wire_pkg.sv ***
// Types for both ends and the address decoding used by the slave end of the two-wire address phase.
`include "two_wire_map.svh"

package two_wire_pkg;

  typedef logic [`TW_ADDR_BITS-1:0] addr7_t;

  typedef enum logic [1:0] {
    DS_ADDR,
    DS_ACK,
    DS_DATA
  } slave_state_t;

  typedef enum logic [2:0] {
    MS_IDLE,
    MS_START,
    MS_LOW,
    MS_HIGH,
    MS_HOLD,
    MS_RESTART,
    MS_RESTART_HIGH,
    MS_STOP
  } master_state_t;

  // True for an address that may be given to a single slave.
  function automatic logic addr_assignable(input addr7_t a);
    return (a != `TW_GC_ADDR) && (a[`TW_RSV_MSB:`TW_RSV_LSB] != `TW_RSV_TOP);
  endfunction

endpackage

// *** src/two_wire_address_packet_device.sv ***
// Slave end of the two-wire address phase: framing, matching and acknowledge.
//
// Functional notes
// - Address packet is seven address, direction, acknowledge.
// - Direction one reads, zero writes.
// - Own address acknowledged low in ninth clock.
// - Busy slave leaves data high at acknowledge.
// - After no acknowledge, master stops or restarts.
// - Address byte travels most significant bit first.
// - All-zero address is general call only.
// - Enabled slaves acknowledge general call write.
// - General call acknowledgers receive following data.
// - Masters never send general call read.
// - Addresses 1111xxx stay reserved, never assigned.
// - Start and stop change data while clock high.
// - Own address upper seven bits, general-call enable low.
// - Mask bit one skips that address bit compare.
// - Own or general-call match raises interrupt request.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"

module two_wire_address_packet_device
  import two_wire_pkg::*;
(
  // System clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Two-wire bus
  two_wire_if.device link,
  // Slave configuration
  input wire logic [7:0] own_slave_address_reg,
  input wire logic [`TW_ADDR_BITS-1:0] address_compare_mask,
  input wire logic slave_busy,
  // Address-phase results
  output logic match_irq,
  output logic [`TW_ADDR_BITS-1:0] matched_addr,
  output logic matched_read,
  output logic matched_general_call,
  output logic matched_acked,
  // Bus and role status
  output logic bus_busy,
  output logic start_seen,
  output logic stop_seen,
  output logic role_transmitter,
  output logic role_receiver
);

  // --------------------------------------------------------------------
  // System domain: bus condition detection
  // --------------------------------------------------------------------
  logic scl_m1_q, scl_m2_q, scl_m3_q;
  logic sda_m1_q, sda_m2_q, sda_m3_q;
  logic start_cond, stop_cond;
  logic frame_open_q, rst_link_q, link_hold;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_m1_q <= 1'b1;
      scl_m2_q <= 1'b1;
      scl_m3_q <= 1'b1;
      sda_m1_q <= 1'b1;
      sda_m2_q <= 1'b1;
      sda_m3_q <= 1'b1;
    end else if (clk_en) begin
      scl_m1_q <= link.scl;
      scl_m2_q <= scl_m1_q;
      scl_m3_q <= scl_m2_q;
      sda_m1_q <= link.sda;
      sda_m2_q <= sda_m1_q;
      sda_m3_q <= sda_m2_q;
    end
  end

  // Data edges while the clock line stays high are framing conditions.
  assign start_cond = scl_m2_q & scl_m3_q & sda_m3_q & ~sda_m2_q;
  assign stop_cond = scl_m2_q & scl_m3_q & ~sda_m3_q & sda_m2_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_open_q <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else if (clk_en) begin
      start_seen <= start_cond;
      stop_seen <= stop_cond;
      if (start_cond) begin
        frame_open_q <= 1'b1;
      end else if (stop_cond) begin
        frame_open_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    rst_link_q <= sys_rst;
  end

  // Link sampling and packet state are held cleared while no frame is open.
  assign link_hold = ~frame_open_q;

  // --------------------------------------------------------------------
  // Link domain: configuration synchronisers
  // --------------------------------------------------------------------
  logic [7:0] own_m1_q, own_m2_q;
  logic [`TW_ADDR_BITS-1:0] mask_m1_q, mask_m2_q;
  logic busy_m1_q, busy_m2_q;

  always_ff @(posedge link.scl) begin
    own_m1_q <= own_slave_address_reg;
    own_m2_q <= own_m1_q;
    mask_m1_q <= address_compare_mask;
    mask_m2_q <= mask_m1_q;
    busy_m1_q <= slave_busy;
    busy_m2_q <= busy_m1_q;
  end

  // --------------------------------------------------------------------
  // Link domain: bit sampling and address decision
  // --------------------------------------------------------------------
  logic pos_sda_q, dir_q, ack_oe_q;
  slave_state_t st_q;
  logic [3:0] cnt_q;
  addr7_t sreg_q;
  logic tx_q, rx_q;
  logic restart, last_bit;
  addr7_t own_addr;
  logic own_hit, gc_hit, any_hit, answer;

  always_ff @(posedge link.scl or posedge link_hold) begin
    if (link_hold) begin
      pos_sda_q <= 1'b1;
    end else begin
      pos_sda_q <= link.sda;
    end
  end

  // Data seen high at the rising edge and low at the falling edge.
  assign restart = pos_sda_q & ~link.sda;
  assign last_bit = (st_q == DS_ADDR) && (cnt_q == 4'(`TW_ADDR_BITS));

  assign own_addr = own_m2_q[`TW_OWN_ADDR_MSB:`TW_OWN_ADDR_LSB];
  assign own_hit = (&((sreg_q ~^ own_addr) | mask_m2_q))
    & addr_assignable(own_addr) & (sreg_q != `TW_GC_ADDR);
  assign gc_hit = (sreg_q == `TW_GC_ADDR) & own_m2_q[`TW_GCE_BIT];
  assign any_hit = own_hit | gc_hit;
  // A general call read is never answered, to avoid data contention.
  assign answer = (own_hit | (gc_hit & (pos_sda_q == `TW_DIR_WRITE)))
    & ~busy_m2_q;

  always_ff @(negedge link.scl or posedge link_hold) begin
    if (link_hold) begin
      st_q <= DS_ADDR;
      cnt_q <= 4'h0;
      sreg_q <= '0;
      dir_q <= 1'b0;
      ack_oe_q <= 1'b0;
      tx_q <= 1'b0;
      rx_q <= 1'b0;
    end else if (restart) begin
      st_q <= DS_ADDR;
      cnt_q <= 4'h0;
      ack_oe_q <= 1'b0;
      tx_q <= 1'b0;
      rx_q <= 1'b0;
    end else begin
      case (st_q)
        DS_ADDR: begin
          if (last_bit) begin
            dir_q <= pos_sda_q;
            ack_oe_q <= answer;
            st_q <= DS_ACK;
          end else begin
            sreg_q <= {sreg_q[`TW_ADDR_BITS-2:0], pos_sda_q};
            cnt_q <= cnt_q + 4'h1;
          end
        end
        DS_ACK: begin
          ack_oe_q <= 1'b0;
          st_q <= DS_DATA;
          if (ack_oe_q) begin
            tx_q <= (dir_q == `TW_DIR_READ);
            rx_q <= (dir_q == `TW_DIR_WRITE);
          end
        end
        DS_DATA: begin
          st_q <= DS_DATA;
        end
        default: begin
          st_q <= DS_ADDR;
        end
      endcase
    end
  end

  assign link.s_sda_oe = ack_oe_q;
  assign link.s_sda_o = 1'b0;

  // --------------------------------------------------------------------
  // Link domain: match event capture
  // --------------------------------------------------------------------
  logic match_tgl_q;
  addr7_t cap_addr_q;
  logic cap_read_q, cap_gc_q, cap_ack_q;

  always_ff @(negedge link.scl or posedge rst_link_q) begin
    if (rst_link_q) begin
      match_tgl_q <= 1'b0;
      cap_addr_q <= '0;
      cap_read_q <= 1'b0;
      cap_gc_q <= 1'b0;
      cap_ack_q <= 1'b0;
    end else if (!link_hold && !restart && last_bit && any_hit) begin
      match_tgl_q <= ~match_tgl_q;
      cap_addr_q <= sreg_q;
      cap_read_q <= pos_sda_q;
      cap_gc_q <= gc_hit & ~own_hit;
      cap_ack_q <= answer;
    end
  end

  // --------------------------------------------------------------------
  // System domain: event and role crossing
  // --------------------------------------------------------------------
  logic tgl_m1_q, tgl_m2_q, tgl_m3_q;
  logic tx_m1_q, rx_m1_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tgl_m1_q <= 1'b0;
      tgl_m2_q <= 1'b0;
      tgl_m3_q <= 1'b0;
      tx_m1_q <= 1'b0;
      role_transmitter <= 1'b0;
      rx_m1_q <= 1'b0;
      role_receiver <= 1'b0;
    end else if (clk_en) begin
      tgl_m1_q <= match_tgl_q;
      tgl_m2_q <= tgl_m1_q;
      tgl_m3_q <= tgl_m2_q;
      tx_m1_q <= tx_q;
      role_transmitter <= tx_m1_q;
      rx_m1_q <= rx_q;
      role_receiver <= rx_m1_q;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      match_irq <= 1'b0;
      matched_addr <= '0;
      matched_read <= 1'b0;
      matched_general_call <= 1'b0;
      matched_acked <= 1'b0;
    end else if (clk_en) begin
      match_irq <= tgl_m2_q ^ tgl_m3_q;
      if (tgl_m2_q ^ tgl_m3_q) begin
        matched_addr <= cap_addr_q;
        matched_read <= cap_read_q;
        matched_general_call <= cap_gc_q;
        matched_acked <= cap_ack_q;
      end
    end
  end

  assign bus_busy = frame_open_q;

endmodule

`default_nettype wire

// *** src/two_wire_address_packet_master.sv ***
// Master end of the two-wire address phase: clock divider and packet sender.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"

module two_wire_address_packet_master
  import two_wire_pkg::*;
#(
  parameter int HALF_CYC = `TW_SCL_HALF_CYC
) (
  // System clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Two-wire bus
  two_wire_if.master link,
  // Address request
  input wire logic req_valid,
  input wire logic [`TW_ADDR_BITS-1:0] req_addr,
  input wire logic req_read,
  input wire logic req_stop,
  output logic req_ready,
  // Address result
  output logic req_done,
  output logic req_acked,
  output logic req_refused
);

  localparam int TW = $clog2(HALF_CYC + 1);

  // --------------------------------------------------------------------
  // Timer and data line synchroniser
  // --------------------------------------------------------------------
  master_state_t st_q;
  logic [TW-1:0] tmr_q;
  logic tick, mid;
  logic sda_m1_q, sda_m2_q;

  assign tick = (tmr_q == TW'(HALF_CYC - 1));
  assign mid = (tmr_q == TW'(1));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tmr_q <= '0;
    end else if (clk_en) begin
      if (st_q == MS_IDLE || st_q == MS_HOLD || tick) begin
        tmr_q <= '0;
      end else begin
        tmr_q <= tmr_q + TW'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sda_m1_q <= 1'b1;
      sda_m2_q <= 1'b1;
    end else if (clk_en) begin
      sda_m1_q <= link.sda;
      sda_m2_q <= sda_m1_q;
    end
  end

  // --------------------------------------------------------------------
  // Packet sequencer
  // --------------------------------------------------------------------
  logic scl_q, sda_oe_q, sda_o_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic ready_q, done_q, acked_q, refused_q;
  logic take, refuse;

  assign take = req_valid & ready_q;
  assign refuse = (req_addr == `TW_GC_ADDR) & (req_read == `TW_DIR_READ);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= MS_IDLE;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
      sda_o_q <= 1'b0;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      acked_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      case (st_q)
        MS_IDLE: begin
          scl_q <= 1'b1;
          sda_oe_q <= 1'b0;
          ready_q <= ~take;
          if (take && refuse) begin
            refused_q <= 1'b1;
          end else if (take) begin
            sh_q <= {req_addr, req_read};
            sda_oe_q <= 1'b1;
            st_q <= MS_START;
          end
        end
        MS_START: begin
          if (tick) begin
            scl_q <= 1'b0;
            bit_q <= 4'h0;
            st_q <= MS_LOW;
          end
        end
        MS_LOW: begin
          if (mid) begin
            sda_oe_q <= (bit_q == 4'(`TW_ACK_BIT_IDX)) ? 1'b0 : ~sh_q[7];
          end
          if (tick) begin
            scl_q <= 1'b1;
            st_q <= MS_HIGH;
          end
        end
        MS_HIGH: begin
          if (tick) begin
            scl_q <= 1'b0;
            if (bit_q == 4'(`TW_ACK_BIT_IDX)) begin
              acked_q <= ~sda_m2_q;
              done_q <= 1'b1;
              ready_q <= 1'b1;
              st_q <= MS_HOLD;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              st_q <= MS_LOW;
            end
          end
        end
        MS_HOLD: begin
          scl_q <= 1'b0;
          sda_oe_q <= 1'b0;
          if (req_stop && ready_q) begin
            ready_q <= 1'b0;
            st_q <= MS_STOP;
          end else if (take && refuse) begin
            refused_q <= 1'b1;
          end else if (take) begin
            ready_q <= 1'b0;
            sh_q <= {req_addr, req_read};
            st_q <= MS_RESTART;
          end
        end
        MS_RESTART: begin
          if (tick) begin
            scl_q <= 1'b1;
            st_q <= MS_RESTART_HIGH;
          end
        end
        MS_RESTART_HIGH: begin
          if (tick) begin
            sda_oe_q <= 1'b1;
            st_q <= MS_START;
          end
        end
        MS_STOP: begin
          if (mid && !scl_q) begin
            sda_oe_q <= 1'b1;
          end
          if (tick && !scl_q) begin
            scl_q <= 1'b1;
          end else if (tick) begin
            sda_oe_q <= 1'b0;
            st_q <= MS_IDLE;
          end
        end
        default: begin
          st_q <= MS_IDLE;
        end
      endcase
    end
  end

  assign link.scl = scl_q;
  assign link.m_sda_oe = sda_oe_q;
  assign link.m_sda_o = sda_o_q;
  assign req_ready = ready_q;
  assign req_done = done_q;
  assign req_acked = acked_q;
  assign req_refused = refused_q;

endmodule

`default_nettype wire

// *** test/two_wire_address_packet_bench.sv ***
// Bench joining the master and device ends over one two-wire carrier.
`timescale 1ns/1ps
`default_nettype none

module two_wire_address_packet_bench;
  logic clock, sys_rst, req_valid, req_read, req_stop, slave_busy, clk_en;
  logic [6:0] req_addr, address_compare_mask, matched_addr, o;
  logic [7:0] own_slave_address_reg;
  logic req_ready, req_done, req_acked, req_refused, match_irq;
  logic matched_read, matched_general_call, matched_acked, bus_busy;
  logic start_seen, stop_seen, role_transmitter, role_receiver;
  int mismatches, cmp_count, cycles, irq_n, start_n, stop_n, ref_n;
  logic bits[$];

  two_wire_if link();
  two_wire_address_packet_master #(.HALF_CYC(4))
  i_two_wire_address_packet_master (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .link(link),
    .req_valid(req_valid), .req_addr(req_addr), .req_read(req_read),
    .req_stop(req_stop), .req_ready(req_ready), .req_done(req_done),
    .req_acked(req_acked), .req_refused(req_refused));
  two_wire_address_packet_device i_two_wire_address_packet_device (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .link(link),
    .own_slave_address_reg(own_slave_address_reg),
    .address_compare_mask(address_compare_mask), .slave_busy(slave_busy),
    .match_irq(match_irq), .matched_addr(matched_addr),
    .matched_read(matched_read), .matched_general_call(matched_general_call),
    .matched_acked(matched_acked), .bus_busy(bus_busy),
    .start_seen(start_seen), .stop_seen(stop_seen),
    .role_transmitter(role_transmitter), .role_receiver(role_receiver));
  two_wire_address_packet_sva i_sva (
    .clock(clock), .sys_rst(sys_rst), .scl(link.scl),
    .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
    .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .sda(link.sda));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // --------------------------------------------------------------------
  // Event counters, wire monitor and timeout
  // --------------------------------------------------------------------
  always @(negedge clock) begin
    cycles++;
    if (match_irq === 1'b1) irq_n++;
    if (start_seen === 1'b1) start_n++;
    if (stop_seen === 1'b1) stop_n++;
    if (req_refused === 1'b1) ref_n++;
    if (cycles > 20000) begin
      mismatches++;
      complete_run();
    end
  end
  always @(posedge link.scl) bits.push_back(link.sda);
  always @(negedge link.sda) if (link.scl === 1'b1) bits.delete();

  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One address packet compared against the reference model.
  task run(input logic [6:0] a, input logic rd, input logic bsy,
           input logic [7:0] own, input logic [6:0] msk, input logic stp);
    logic [6:0] ow;
    logic gc, hit, ack, own_ok;
    int n, i0, s0, p0, r0;
    ow = own[7:1];
    own_ok = ow != 7'h00 && ow[6:3] != 4'hF;
    gc = a == 7'h00 && own[0];
    hit = own_ok && a != 7'h00 && ((a ^ ow) & ~msk) == 7'h00;
    ack = !bsy && (hit || (gc && !rd));
    i0 = irq_n;
    s0 = start_n;
    p0 = stop_n;
    r0 = ref_n;
    @(negedge clock);
    req_addr = a;
    req_read = rd;
    slave_busy = bsy;
    own_slave_address_reg = own;
    address_compare_mask = msk;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 1'b0;
    if (a == 7'h00 && rd) begin
      repeat (4) @(negedge clock);
      check(8'(ref_n - r0), 8'h01);
      check(8'(start_n - s0), 8'h00);
      $display("test done: refused read of address %h", a);
      return;
    end
    clk_en = 1'b0;
    repeat (3) @(negedge clock);
    clk_en = 1'b1;
    n = 0;
    while (req_done !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    repeat (6) @(negedge clock);
    check(8'(req_acked), 8'(ack));
    check(8'(bits.size()), 8'h09);
    for (int k = 0; k < 7; k++) check(8'(bits[k]), 8'(a[6-k]));
    check(8'(bits[7]), 8'(rd));
    check(8'(bits[8]), 8'(!ack));
    check(8'(start_n - s0), 8'h01);
    check(8'(irq_n - i0), 8'(hit || gc));
    if (hit || gc) begin
      check(8'(matched_addr), 8'(a));
      check(8'(matched_read), 8'(rd));
      check(8'(matched_general_call), 8'(a == 7'h00));
      check(8'(matched_acked), 8'(ack));
    end
    check(8'(role_transmitter), 8'(ack && rd));
    check(8'(role_receiver), 8'(ack && !rd));
    if (stp) begin
      req_stop = 1'b1;
      n = 0;
      while (bus_busy !== 1'b0 && n < 200) begin
        @(negedge clock);
        n++;
      end
      req_stop = 1'b0;
      repeat (4) @(negedge clock);
      check(8'(bus_busy), 8'h00);
      check(8'(stop_n - p0), 8'h01);
      check(8'(role_receiver | role_transmitter), 8'h00);
    end
    $display("test done: address %h read %0d ack %0d", a, rd, ack);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_stop = 1'b0;
    slave_busy = 1'b0;
    req_addr = 7'h00;
    address_compare_mask = 7'h00;
    own_slave_address_reg = 8'h00;
    o = 7'($urandom(32'h211C0580));
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    repeat (2) @(negedge clock);
    run(7'h2A, 1'b0, 1'b0, {7'h2A, 1'b1}, 7'h00, 1'b1);
    run(7'h2A, 1'b1, 1'b0, {7'h2A, 1'b0}, 7'h00, 1'b0);
    run(7'h11, 1'b0, 1'b0, {7'h2A, 1'b0}, 7'h00, 1'b1);
    run(7'h2A, 1'b0, 1'b1, {7'h2A, 1'b1}, 7'h00, 1'b1);
    run(7'h00, 1'b0, 1'b0, {7'h2A, 1'b1}, 7'h00, 1'b1);
    run(7'h00, 1'b0, 1'b0, {7'h2A, 1'b0}, 7'h00, 1'b1);
    run(7'h00, 1'b1, 1'b0, {7'h2A, 1'b1}, 7'h00, 1'b0);
    run(7'h25, 1'b1, 1'b0, {7'h2A, 1'b0}, 7'h0F, 1'b1);
    run(7'h78, 1'b0, 1'b0, {7'h78, 1'b0}, 7'h00, 1'b1);
    for (int t = 0; t < 8; t++) begin
      o = 7'h10 + 7'($urandom % 96);
      run(o ^ (7'($urandom) & 7'h07), 1'($urandom), 1'($urandom),
          {o, 1'($urandom)}, 7'($urandom) & 7'h07, 1'b1);
    end
    complete_run();
  end
endmodule

`default_nettype wire

// *** test/two_wire_address_packet_sva.sv ***
// Concurrent checks on the two-wire bus signals between the two ends.
`timescale 1ns/1ps
`default_nettype none

module two_wire_address_packet_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bus signals
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------------
  // Assertions (timing figures assume a clock half period of 4 cycles)
  // --------------------------------------------------------------------
  a_master_only_low: assert property (m_sda_oe |-> !m_sda_o)
    else $error("master drives the data line high");
  a_device_only_low: assert property (s_sda_oe |-> !s_sda_o)
    else $error("device drives the data line high");
  a_ack_scl_low: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("device changes data while clock is high");
  a_ack_master_off: assert property (s_sda_oe && scl |-> !m_sda_oe)
    else $error("master drives data in the acknowledge slot");
  a_ack_one_period: assert property (
    $rose(s_sda_oe) |-> s_sda_oe [*8] ##1 !s_sda_oe)
    else $error("acknowledge does not last one clock period");
  a_ack_pulls_low: assert property (s_sda_oe |-> !sda)
    else $error("data line not low during acknowledge");
  a_scl_high_len: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  a_scl_low_len: assert property ($fell(scl) |-> !scl [*4])
    else $error("clock low phase too short");

  c_ack: cover property ($rose(s_sda_oe));
  c_start: cover property ($fell(sda) && scl && $past(scl));
  c_stop: cover property ($rose(sda) && scl && $past(scl));
endmodule

`default_nettype wire
